/* File: pkg/cdp_defs.svh */
// offsets, field positions, masks and reset values of the cache debug block
// Contract
// RULE_01: secure and non-secure accesses may both read both control registers.
// RULE_02: non-secure writes get an error answer and change nothing.
// RULE_03: debug bit 2 shows the synchronised debug input; bits 31:3 read zero.
// RULE_04: debug bit 1 forces write-through when set; zero keeps write-back.
// RULE_05: forced write-through makes cacheable writes write-through, no allocate.
// RULE_06: forced write-through never cleans dirty lines on a write.
// RULE_07: forced write-through never marks a clean line dirty.
// RULE_08: forced write-through write to dirty line updates line and memory.
// RULE_09: debug bit 0 set stops every allocation on reads and writes.
// RULE_10: linefill disabled: hits from cache, cacheable misses read memory directly.
// RULE_11: the two debug bits win over forced allocate and exclusive mode.
// RULE_12: prefetch bit 30 picks eight-beat instead of four-beat miss bursts.
// RULE_13: prefetch bit 29 enables instruction prefetching, reset off.
// RULE_14: prefetch bit 28 enables data prefetching, reset off.
// RULE_15: prefetch bit 27 set disables double linefill for wrapping reads.
// RULE_16: prefetch bit 26 reads zero with speculative reads built, else one.
// RULE_17: prefetch bit 24 set drops prefetches that conflict with explicit reads.
// RULE_18: prefetch bit 23 set allows incrementing eight-beat miss bursts.
// RULE_19: prefetch bit 21 set gives exclusive read and write different IDs.
// RULE_20: software writes only offsets 0 to 7, 15, 23 or 31.
// RULE_21: software keeps reserved prefetch bits by read-modify-write.
// RULE_22: prefetch enables also in aux register; prefetch register always writable.
// RULE_23: new settings apply to transactions accepted after the write.
`ifndef CDP_DEFS_SVH
`define CDP_DEFS_SVH
`define CDP_OFS_DBG     8'h00
`define CDP_OFS_PF      8'h04
`define CDP_OFS_AUX     8'h08
`define CDP_DBG_LFD     0
`define CDP_DBG_FWT     1
`define CDP_DBG_SPN     2
`define CDP_PF_DLF      30
`define CDP_PF_IPF      29
`define CDP_PF_DPF      28
`define CDP_PF_WRD      27
`define CDP_PF_SPEC     26
`define CDP_PF_DROP     24
`define CDP_PF_INCR     23
`define CDP_PF_NSID     21
`define CDP_PF_OFS_MSB  4
`define CDP_DBG_WMASK   32'h0000_0003
`define CDP_PF_WMASK    32'h79A0_001F
`define CDP_AUX_WMASK   32'h3000_0000
`define CDP_RST_WORD    32'h0000_0000
`endif

/* File: pkg/cdp_pkg.sv */
// types shared by the cache debug and prefetch control block
`default_nettype none
package cdp_pkg;
  // bus answer state
  typedef enum logic { CDP_IDLE, CDP_ANSWER } cdp_bus_st_t;
  // transaction attributes presented by the cache datapath
  typedef struct packed {
    logic cacheable;
    logic write;
    logic wback;
    logic hit;
    logic dirty;
    logic wr_alloc;
    logic force_wa;
    logic excl_cfg;
    logic wrap;
    logic prefetch;
    logic conflict;
    logic excl_nc;
  } cdp_txn_t;
  // policy decided for one accepted transaction
  typedef struct packed {
    logic       allocate;
    logic       write_through;
    logic       set_dirty;
    logic       write_line;
    logic       write_mem;
    logic       mem_direct;
    logic       burst8;
    logic       incr8;
    logic       drop;
    logic       diff_id;
    logic       ipf_en;
    logic       dpf_en;
    logic [4:0] pf_offset;
  } cdp_dec_t;
endpackage : cdp_pkg
`default_nettype wire

/* File: rtl/cdp_sync.sv */
// two-stage synchroniser for a pin input
`timescale 1ns/1ns
`default_nettype none
module cdp_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_ff;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      sync_o  <= 1'b0;
    end else begin
      meta_ff <= async_i;
      sync_o  <= meta_ff;
    end
  end
endmodule : cdp_sync
`default_nettype wire

/* File: rtl/cdp_lane_merge.sv */
// byte-lane merge of a bus write into a register word under a field mask
`timescale 1ns/1ns
`default_nettype none
module cdp_lane_merge #(
  parameter int LANES = 4
) (
  input  wire logic [8*LANES-1:0] old_i,
  input  wire logic [8*LANES-1:0] wdata_i,
  input  wire logic [8*LANES-1:0] mask_i,
  input  wire logic [LANES-1:0]   sel_i,
  output logic      [8*LANES-1:0] new_o
);
  // one lane per byte select; unselected lanes and masked bits keep old value
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [7:0] m;
    assign m = sel_i[g] ? mask_i[8*g +: 8] : 8'h00;
    assign new_o[8*g +: 8] = (wdata_i[8*g +: 8] & m) | (old_i[8*g +: 8] & ~m);
  end
endmodule : cdp_lane_merge
`default_nettype wire

/* File: rtl/cdp_top.sv */
// cache debug and prefetch control registers with policy steering
`timescale 1ns/1ns
`default_nettype none
`include "cdp_defs.svh"
module cdp_top #(
  parameter int       AW         = 8,
  parameter bit       SPEC_READ  = 1'b0
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [AW-1:0]   wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  input  wire logic            wb_secure_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  output logic                 wb_err_o,
  input  wire logic            spn_debug_i,
  input  wire logic            cache_enable_i,
  input  wire logic            txn_valid_i,
  input  wire cdp_pkg::cdp_txn_t txn_i,
  output logic                 dec_valid_o,
  output cdp_pkg::cdp_dec_t    dec_o,
  output logic                 force_wt_o,
  output logic                 linefill_off_o
);

  ////////////////////////////////////////////////////////////////////////
  // register state and bus decode

  cdp_pkg::cdp_bus_st_t st_ff;
  logic [31:0] pf_ff;
  logic        spn_sync;
  logic        req;
  logic        hit_dbg;
  logic        hit_pf;
  logic        hit_aux;
  logic        mapped;
  logic        wr_ok;
  logic [31:0] nxt_dbg;
  logic [31:0] nxt_pf;
  logic [31:0] nxt_aux;
  logic [31:0] rd_word;
  logic [31:0] dbg_word;
  logic [31:0] pf_word;
  logic [31:0] aux_word;

  // debug pin crosses in through two flops
  cdp_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (spn_debug_i),
    .sync_o  (spn_sync)
  );

  // request seen only while idle, so each bus cycle is answered once
  assign req     = wb_cyc_i && wb_stb_i && (st_ff == cdp_pkg::CDP_IDLE);
  assign hit_dbg = (wb_adr_i == `CDP_OFS_DBG);
  assign hit_pf  = (wb_adr_i == `CDP_OFS_PF);
  assign hit_aux = (wb_adr_i == `CDP_OFS_AUX);
  assign mapped  = hit_dbg || hit_pf || hit_aux;
  // only secure masters may change the settings
  assign wr_ok   = req && wb_we_i && mapped && wb_secure_i; // RULE_02

  ////////////////////////////////////////////////////////////////////////
  // read views

  // live debug input in bit 2, zero above
  always_comb begin
    dbg_word = `CDP_RST_WORD; // RULE_03
    dbg_word[`CDP_DBG_LFD] = linefill_off_o;
    dbg_word[`CDP_DBG_FWT] = force_wt_o;
    dbg_word[`CDP_DBG_SPN] = spn_sync; // RULE_03
  end

  // prefetch view: stored fields plus the build-option bit
  always_comb begin
    pf_word = pf_ff & `CDP_PF_WMASK;
    pf_word[`CDP_PF_SPEC] = ~SPEC_READ; // RULE_16
  end

  // aux view carries only the aliased prefetch enables
  assign aux_word = pf_ff & `CDP_AUX_WMASK; // RULE_22

  // read data select; both security states may read
  always_comb begin
    case (1'b1)
      hit_dbg: rd_word = dbg_word; // RULE_01
      hit_pf:  rd_word = pf_word;  // RULE_01
      hit_aux: rd_word = aux_word;
      default: rd_word = `CDP_RST_WORD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // write merge under byte selects and field masks

  cdp_lane_merge u_mrg_dbg (
    .old_i   (dbg_word),
    .wdata_i (wb_dat_i),
    .mask_i  (`CDP_DBG_WMASK),
    .sel_i   (wb_sel_i),
    .new_o   (nxt_dbg)
  );

  // reserved bits are not stored, so a careless write cannot corrupt them
  cdp_lane_merge u_mrg_pf (
    .old_i   (pf_ff),
    .wdata_i (wb_dat_i),
    .mask_i  (`CDP_PF_WMASK),
    .sel_i   (wb_sel_i),
    .new_o   (nxt_pf)
  );

  cdp_lane_merge u_mrg_aux (
    .old_i   (pf_ff),
    .wdata_i (wb_dat_i),
    .mask_i  (`CDP_AUX_WMASK),
    .sel_i   (wb_sel_i),
    .new_o   (nxt_aux)
  );

  ////////////////////////////////////////////////////////////////////////
  // debug control bits

  // write policy and linefill switch, secure writes only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      force_wt_o     <= 1'b0;
      linefill_off_o <= 1'b0;
    end else if (wr_ok && hit_dbg) begin
      force_wt_o     <= nxt_dbg[`CDP_DBG_FWT]; // RULE_04
      linefill_off_o <= nxt_dbg[`CDP_DBG_LFD]; // RULE_09
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prefetch policy bits

  // prefetch register writable at any time; aux copy only with cache off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pf_ff <= `CDP_RST_WORD;
    end else if (wr_ok && hit_pf) begin
      pf_ff <= nxt_pf; // RULE_22
    end else if (wr_ok && hit_aux && !cache_enable_i) begin
      pf_ff <= nxt_aux; // RULE_22
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus answer

  // one-cycle answer, dropped in the following cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff    <= cdp_pkg::CDP_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= `CDP_RST_WORD;
    end else begin
      case (st_ff)
        cdp_pkg::CDP_IDLE: begin
          if (req) begin
            st_ff    <= cdp_pkg::CDP_ANSWER;
            wb_ack_o <= mapped && (!wb_we_i || wb_secure_i); // RULE_01
            wb_err_o <= !mapped || (wb_we_i && !wb_secure_i); // RULE_02
            wb_dat_o <= wb_we_i ? `CDP_RST_WORD : rd_word;
          end
        end
        cdp_pkg::CDP_ANSWER: begin
          st_ff    <= cdp_pkg::CDP_IDLE;
          wb_ack_o <= 1'b0;
          wb_err_o <= 1'b0;
        end
        default: begin
          st_ff    <= cdp_pkg::CDP_IDLE;
          wb_ack_o <= 1'b0;
          wb_err_o <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // policy steering for accepted transactions

  cdp_pkg::cdp_dec_t nxt_dec;
  logic fwt;
  logic lfd;
  logic miss;

  assign fwt  = force_wt_o;
  assign lfd  = linefill_off_o;
  assign miss = txn_i.cacheable && !txn_i.hit;

  // settings seen in the accept cycle are frozen into the decision
  always_comb begin
    nxt_dec = '0;
    // forced write-through beats the access attribute
    nxt_dec.write_through = txn_i.write && txn_i.cacheable &&
                            (fwt || !txn_i.wback); // RULE_05
    // debug bits win over forced allocate and exclusive mode
    nxt_dec.allocate = miss && !lfd && !(fwt && txn_i.write) &&
                       (!txn_i.write || txn_i.wr_alloc ||
                        txn_i.force_wa); // RULE_09 RULE_11
    // never dirty under forced write-through; dirty lines keep state
    nxt_dec.set_dirty = txn_i.write && txn_i.cacheable && txn_i.hit &&
                        !nxt_dec.write_through; // RULE_06 RULE_07
    nxt_dec.write_line = txn_i.write && txn_i.cacheable &&
                         (txn_i.hit || nxt_dec.allocate); // RULE_08
    nxt_dec.write_mem = txn_i.write && (!txn_i.cacheable ||
                        nxt_dec.write_through ||
                        !nxt_dec.write_line); // RULE_08
    // misses without allocation go straight to memory
    nxt_dec.mem_direct = !txn_i.write && miss &&
                         !nxt_dec.allocate; // RULE_10
    nxt_dec.burst8 = !txn_i.write && nxt_dec.allocate &&
                     pf_ff[`CDP_PF_DLF] &&
                     !(txn_i.wrap && pf_ff[`CDP_PF_WRD]); // RULE_12 RULE_15
    nxt_dec.incr8 = nxt_dec.burst8 && !txn_i.wrap &&
                    pf_ff[`CDP_PF_INCR]; // RULE_18
    nxt_dec.drop = txn_i.prefetch && txn_i.conflict &&
                   pf_ff[`CDP_PF_DROP]; // RULE_17
    nxt_dec.diff_id = txn_i.excl_nc && pf_ff[`CDP_PF_NSID]; // RULE_19
    nxt_dec.ipf_en = pf_ff[`CDP_PF_IPF]; // RULE_13
    nxt_dec.dpf_en = pf_ff[`CDP_PF_DPF]; // RULE_14
    nxt_dec.pf_offset = pf_ff[`CDP_PF_OFS_MSB:0]; // RULE_20
  end

  // decision register, loaded only when a transaction is accepted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_valid_o <= 1'b0;
      dec_o       <= '0;
    end else begin
      dec_valid_o <= txn_valid_i;
      if (txn_valid_i) begin
        dec_o <= nxt_dec; // RULE_23
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req_wr_dbg;
    req && wb_we_i && hit_dbg && wb_sel_i[0];
  endsequence

  sequence s_req_rd(logic h);
    req && !wb_we_i && h;
  endsequence

  a_read_any_ok: assert property ( // RULE_01
    s_req_rd(mapped) |=> wb_ack_o && !wb_err_o ##1 !wb_ack_o)
    else $error("mapped read not acknowledged");

  a_nonsec_blocked: assert property ( // RULE_02
    req && wb_we_i && mapped && !wb_secure_i |=>
      wb_err_o && !wb_ack_o && $stable(pf_ff) && $stable(force_wt_o) &&
      $stable(linefill_off_o))
    else $error("non-secure write not refused");

  a_dbg_readback: assert property ( // RULE_03
    s_req_rd(hit_dbg) |=> wb_dat_o[2] == $past(spn_sync) &&
      wb_dat_o[31:3] == 29'h0000_0000)
    else $error("debug read value wrong");

  a_fwt_update: assert property ( // RULE_04
    s_req_wr_dbg ##0 wb_secure_i |=> force_wt_o == $past(wb_dat_i[1]))
    else $error("write-through bit not updated");

  a_lfd_update: assert property ( // RULE_09
    s_req_wr_dbg ##0 wb_secure_i |=> linefill_off_o == $past(wb_dat_i[0]))
    else $error("linefill bit not updated");

  a_spec_bit: assert property ( // RULE_16
    s_req_rd(hit_pf) |=> wb_dat_o[26] == !SPEC_READ)
    else $error("speculative option bit wrong");

  a_pf_anytime: assert property ( // RULE_22
    req && wb_we_i && hit_pf && wb_secure_i && wb_sel_i[3] |=>
      pf_ff[30:27] == $past(wb_dat_i[30:27]))
    else $error("prefetch write lost");

  a_fwt_no_alloc: assert property ( // RULE_05
    txn_valid_i && force_wt_o && txn_i.write && txn_i.cacheable |=>
      dec_o.write_through && !dec_o.allocate && !dec_o.set_dirty)
    else $error("forced write-through ignored");

  a_dirty_hit_both: assert property ( // RULE_08
    txn_valid_i && force_wt_o && txn_i.write && txn_i.cacheable &&
    txn_i.hit && txn_i.dirty |=> dec_o.write_line && dec_o.write_mem)
    else $error("dirty hit not written both ways");

  a_lfd_direct: assert property ( // RULE_10
    txn_valid_i && linefill_off_o && !txn_i.write && txn_i.cacheable &&
    !txn_i.hit |=> dec_o.mem_direct && !dec_o.allocate)
    else $error("linefill disable did not bypass");

  a_burst_len: assert property ( // RULE_12
    txn_valid_i && !pf_ff[30] |=> !dec_o.burst8)
    else $error("long burst while disabled");

  a_drop_off: assert property ( // RULE_17
    txn_valid_i && !pf_ff[24] |=> !dec_o.drop)
    else $error("prefetch dropped while disabled");

  a_excl_id: assert property ( // RULE_19
    txn_valid_i && txn_i.excl_nc |=> dec_o.diff_id == $past(pf_ff[21]))
    else $error("exclusive id policy wrong");

  a_dec_hold: assert property ( // RULE_23
    !txn_valid_i |=> $stable(dec_o))
    else $error("decision changed in flight");

  // a clean line never turns dirty while write-through is forced
  a_clean_no_dirty: assert property ( // RULE_07
    txn_valid_i && force_wt_o && txn_i.write && !txn_i.dirty |=>
      !dec_o.set_dirty)
    else $error("clean line marked dirty");

  a_ipf_follow: assert property ( // RULE_13
    txn_valid_i |=> dec_o.ipf_en == $past(pf_ff[29]))
    else $error("instruction prefetch enable wrong");

  a_dpf_follow: assert property ( // RULE_14
    txn_valid_i |=> dec_o.dpf_en == $past(pf_ff[28]))
    else $error("data prefetch enable wrong");

  // wrapping reads stay single length while the wrap disable is set
  a_wrap_no_double: assert property ( // RULE_15
    txn_valid_i && txn_i.wrap && pf_ff[27] |=> !dec_o.burst8)
    else $error("double linefill on wrapping read");

  a_incr_gate: assert property ( // RULE_18
    txn_valid_i && !pf_ff[23] |=> !dec_o.incr8)
    else $error("incrementing burst while disabled");

  // linefill disable beats forced write-allocate
  a_lfd_beats_wa: assert property ( // RULE_11
    txn_valid_i && linefill_off_o && txn_i.force_wa |=> !dec_o.allocate)
    else $error("allocation despite linefill disable");

endmodule : cdp_top
`default_nettype wire

/* File: test/cdp_wb_master.sv */
// classic wishbone master model standing for the register-side bus masters
`timescale 1ns/1ns
`default_nettype none
module cdp_wb_master (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        sec_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [31:0] rdat_i,
  output logic             cyc_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o,
  output logic             sec_o,
  output logic             done_o,
  output logic             berr_o,
  output logic [31:0]      rdat_o
);
  // one request at a time, held until ack or err is sampled high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_o  <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!cyc_o && req_i) begin
        cyc_o <= 1'b1;
        we_o  <= we_i;
        adr_o <= adr_i;
        sel_o <= sel_i;
        dat_o <= dat_i;
        sec_o <= sec_i;
      end else if (cyc_o && (ack_i || err_i)) begin
        cyc_o  <= 1'b0;
        done_o <= 1'b1;
        rdat_o <= rdat_i;
        berr_o <= err_i;
        dat_o  <= ~dat_o; // released lines stop showing the old value
        adr_o  <= ~adr_o;
      end
    end
  end
endmodule : cdp_wb_master
`default_nettype wire

/* File: test/cdp_tb_top.sv */
// testbench for the cache debug and prefetch control block
`timescale 1ns/1ns
`default_nettype none
module cdp_tb_top;
  logic              clk_i, rst_i, req, we, sec, done, berr, cyc, mwe;
  logic              msec, ack, err, spn, cen, tv, dv, fwt, lfo;
  logic [7:0]        adr, madr;
  logic [3:0]        sel, msel;
  logic [31:0]       wd, mdat, rdat, dato, dato_s;
  cdp_pkg::cdp_txn_t txn;
  cdp_pkg::cdp_dec_t dec;
  int                num_errors, checked;

  cdp_top i_cdp_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(mwe), .wb_adr_i(madr), .wb_sel_i(msel),
    .wb_dat_i(mdat), .wb_secure_i(msec), .wb_dat_o(dato), .wb_ack_o(ack),
    .wb_err_o(err), .spn_debug_i(spn), .cache_enable_i(cen),
    .txn_valid_i(tv), .txn_i(txn), .dec_valid_o(dv), .dec_o(dec),
    .force_wt_o(fwt), .linefill_off_o(lfo));
  cdp_wb_master i_cdp_wb_master (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .sec_i(sec),
    .ack_i(ack), .err_i(err), .rdat_i(dato), .cyc_o(cyc), .we_o(mwe),
    .adr_o(madr), .sel_o(msel), .dat_o(mdat), .sec_o(msec), .done_o(done),
    .berr_o(berr), .rdat_o(rdat));
  // second copy built with the speculative-read option, read data only
  cdp_top #(.SPEC_READ(1'b1)) i_cdp_top_spec (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(mwe), .wb_adr_i(madr),
    .wb_sel_i(msel), .wb_dat_i(mdat), .wb_secure_i(msec), .wb_dat_o(dato_s),
    .wb_ack_o(), .wb_err_o(), .spn_debug_i(spn), .cache_enable_i(cen),
    .txn_valid_i(tv), .txn_i(txn), .dec_valid_o(), .dec_o(),
    .force_wt_o(), .linefill_off_o());

  ////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  // one bus cycle through the master model, error answer compared
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d, input logic sc, input logic ee);
    @(posedge clk_i);
    req <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    wd  <= d;
    sec <= sc;
    @(posedge clk_i);
    req <= 1'b0;
    @(negedge clk_i);
    // the done pulse ends the wait; only the watchdog ends a wait with no answer
    while (done !== 1'b1) begin
      @(negedge clk_i);
    end
    check("bus error", {31'h0, berr}, {31'h0, ee});
  endtask : acc

  task automatic rd(input logic [7:0] a, input logic sc,
                    input logic [31:0] exp, input string what);
    acc(1'b0, a, 4'hF, 32'h0000_0000, sc, 1'b0);
    check(what, rdat, exp);
  endtask : rd

  // one accepted transaction and the decision one cycle later
  task automatic tx(input logic [11:0] t, input logic [16:0] e);
    @(posedge clk_i);
    tv  <= 1'b1;
    txn <= t;
    @(posedge clk_i);
    tv  <= 1'b0;
    txn <= ~t;
    @(negedge clk_i);
    check("decision valid", {31'h0, dv}, 32'h0000_0001);
    check("decision", {15'h0, dec}, {15'h0, e});
  endtask : tx

  ////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    #(40 * 4000);
    num_errors++;
    conclude();
  end

  // main sequence
  initial begin
    num_errors = 0;
    checked = 0;
    rst_i = 1'b1;
    {req, we, sec, spn, cen, tv} = '0;
    adr = 8'h00;
    sel = 4'h0;
    wd  = 32'h0000_0000;
    txn = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 1'b1, 32'h0000_0000, "debug reset");
    rd(8'h04, 1'b0, 32'h0400_0000, "prefetch reset");
    check("spec option", dato_s, 32'h0000_0000);
    check("force wt reset", {31'h0, fwt}, 32'h0000_0000);
    tx(12'h827, 17'h1_0000);
    $display("test reset values done");
    @(posedge clk_i);
    spn <= 1'b1;
    repeat (3) @(posedge clk_i);
    acc(1'b1, 8'h00, 4'hF, 32'hFFFF_FFFF, 1'b1, 1'b0);
    rd(8'h00, 1'b1, 32'h0000_0007, "debug set");
    check("force wt", {31'h0, fwt}, 32'h0000_0001);
    check("linefill off", {31'h0, lfo}, 32'h0000_0001);
    acc(1'b1, 8'h00, 4'hF, 32'h0000_0000, 1'b0, 1'b1);
    rd(8'h00, 1'b0, 32'h0000_0007, "debug ns");
    $display("test debug register done");
    @(posedge clk_i);
    cen <= 1'b1;
    // read value with mask bits set, offset 31 is a supported value
    acc(1'b1, 8'h04, 4'hF, 32'h7DA0_001F, 1'b1, 1'b0);
    rd(8'h04, 1'b1, 32'h7DA0_001F, "prefetch set");
    acc(1'b1, 8'h04, 4'h1, 32'h0000_0000, 1'b1, 1'b0);
    rd(8'h04, 1'b1, 32'h7DA0_0000, "prefetch lane");
    acc(1'b1, 8'h04, 4'hF, 32'h0000_0000, 1'b0, 1'b1);
    rd(8'h04, 1'b0, 32'h7DA0_0000, "prefetch ns");
    rd(8'h08, 1'b1, 32'h3000_0000, "aux alias");
    // aux copy is locked while the cache is on, writable once it is off
    acc(1'b1, 8'h08, 4'hF, 32'h0000_0000, 1'b1, 1'b0);
    rd(8'h08, 1'b1, 32'h3000_0000, "aux locked");
    @(posedge clk_i);
    cen <= 1'b0;
    acc(1'b1, 8'h08, 4'hF, 32'h0000_0000, 1'b1, 1'b0);
    rd(8'h04, 1'b1, 32'h4DA0_0000, "aux write");
    acc(1'b1, 8'h08, 4'h8, 32'h3000_0000, 1'b1, 1'b0);
    rd(8'h08, 1'b1, 32'h3000_0000, "aux restore");
    acc(1'b0, 8'h0C, 4'hF, 32'h0000_0000, 1'b1, 1'b1);
    $display("test prefetch register done");
    tx(12'hFF0, 17'h0_B060);
    tx(12'hE60, 17'h0_9060);
    tx(12'h827, 17'h0_09E0);
    acc(1'b1, 8'h00, 4'hF, 32'h0000_0000, 1'b1, 1'b0);
    tx(12'h827, 17'h1_07E0);
    tx(12'h82F, 17'h1_01E0);
    tx(12'hF00, 17'h0_6060);
    tx(12'hE60, 17'h1_2060);
    $display("test policy decisions done");
    conclude();
  end
endmodule : cdp_tb_top
`default_nettype wire
